//--- gpp_pkg.sv
// Constants shared by the eight-bit port and its pin cell.
// Assumes one 20 MHz clock and a core that issues single read/write strobes.
// What this block does
// - Eight pins, each usable as input, output or shared peripheral pin.
// - Outputs held in per-bit latches; input levels are only registered each clock for the peripherals.
// - Pin levels are sampled in the first machine state of a read.
// - Driven pin values change in the second machine state of a write.
// - Reset sets latches to one and drive-type bits to zero.
// - Drive-type zero gives sink-only open drain; one gives push-pull.
// - Reading the latch location returns latch contents, not pins.
// - A separate read-only location returns the live pin levels.
`default_nettype none
package gpp_pkg;
	localparam int        GPP_WIDTH       = 8;
	// Core-side locations
	localparam logic [7:0] GPP_OFS_LATCH  = 8'h00;
	localparam logic [7:0] GPP_OFS_DRIVE  = 8'h08;
	localparam logic [7:0] GPP_OFS_PINS   = 8'h0B;
	// Reset values and unmapped read value
	localparam logic [7:0] GPP_LATCH_RST  = 8'hFF;
	localparam logic [7:0] GPP_DRIVE_RST  = 8'h00;
	localparam logic [7:0] GPP_UNMAPPED   = 8'h00;
	// Drive-type encodings
	localparam logic       GPP_DRV_OPEN   = 1'b0;
	localparam logic       GPP_DRV_PUSH   = 1'b1;
	// Machine states, one clock each
	typedef enum logic [1:0] {
		GPP_MS_FIRST,
		GPP_MS_SECOND,
		GPP_MS_THIRD,
		GPP_MS_FOURTH
	} gpp_ms_t;
endpackage
`default_nettype wire

//--- gpp_pin_cell.sv
// One port bit: output latch, drive-type bit and registered pad drive.
// Assumes write enables are already aligned to the second machine state.
`timescale 1ns/100ps
`default_nettype none
module gpp_pin_cell
	import gpp_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Core writes
	input  wire logic wr_latch,
	input  wire logic wr_drive,
	input  wire logic wdata,
	// Shared peripheral output, one when idle
	input  wire logic periph_out,
	// State and pad
	output logic      latch_r,
	output logic      drive_r,
	output logic      pin_o_r,
	output logic      pin_oe_r
);
	logic latch_nxt;
	logic drive_nxt;
	logic level;

	// Next values of the stored bits
	always_comb begin
		latch_nxt = wr_latch ? wdata : latch_r;
		drive_nxt = wr_drive ? wdata : drive_r;
		level     = latch_nxt & periph_out;
	end

	// Latch and drive-type storage
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			latch_r <= GPP_LATCH_RST[0];
			drive_r <= GPP_DRIVE_RST[0];
		end else begin
			latch_r <= latch_nxt;
			drive_r <= drive_nxt;
		end
	end

	// Pad drive: open drain only pulls low, push-pull drives both levels
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pin_o_r  <= 1'b0;
			pin_oe_r <= 1'b0;
		end else if (drive_nxt == GPP_DRV_PUSH) begin
			pin_o_r  <= level;
			pin_oe_r <= 1'b1;
		end else begin
			pin_o_r  <= 1'b0;
			pin_oe_r <= ~level;
		end
	end
endmodule
`default_nettype wire

//--- gpp_port.sv
// Eight-bit bidirectional port with latch, drive-type and pin-level locations.
// Assumes the core holds a strobe until it is taken; pins are synchronous.
`timescale 1ns/100ps
`default_nettype none
module gpp_port
	import gpp_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Core access
	input  wire logic [7:0] core_addr,
	input  wire logic       core_rd,
	input  wire logic       core_wr,
	input  wire logic [7:0] core_wdata,
	output logic      [7:0] core_rdata_r,
	output logic            core_rd_done_r,
	output logic            core_wr_done_r,
	output logic            core_busy_r,
	// Shared peripherals
	input  wire logic [7:0] periph_out,
	output logic      [7:0] periph_in_r,
	// Pins
	input  wire logic [7:0] pin_i,
	output logic      [7:0] pin_o,
	output logic      [7:0] pin_oe,
	// Machine state
	output gpp_ms_t         mstate_r
);
	logic       rd_pend_r;
	logic       wr_pend_r;
	logic [7:0] rd_addr_r;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic [7:0] latch_q;
	logic [7:0] drive_q;
	logic       rd_take;
	logic       wr_take;
	logic       rd_fire;
	logic       wr_fire;

	assign rd_take = core_rd & ~rd_pend_r;
	assign wr_take = core_wr & ~wr_pend_r;
	assign rd_fire = rd_pend_r & (mstate_r == GPP_MS_FIRST);
	assign wr_fire = wr_pend_r & (mstate_r == GPP_MS_SECOND);

	// Machine state sequencer, one state per clock
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			mstate_r <= GPP_MS_FIRST;
		end else begin
			unique case (mstate_r)
				GPP_MS_FIRST:  mstate_r <= GPP_MS_SECOND;
				GPP_MS_SECOND: mstate_r <= GPP_MS_THIRD;
				GPP_MS_THIRD:  mstate_r <= GPP_MS_FOURTH;
				GPP_MS_FOURTH: mstate_r <= GPP_MS_FIRST;
			endcase
		end
	end

	// Read request capture
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rd_pend_r <= 1'b0;
			rd_addr_r <= 8'h00;
		end else if (rd_take) begin
			rd_pend_r <= 1'b1;
			rd_addr_r <= core_addr;
		end else if (rd_fire) begin
			rd_pend_r <= 1'b0;
		end
	end

	// Write request capture
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else if (wr_take) begin
			wr_pend_r <= 1'b1;
			wr_addr_r <= core_addr;
			wr_data_r <= core_wdata;
		end else if (wr_fire) begin
			wr_pend_r <= 1'b0;
		end
	end

	// Read data: latch, drive type, or live pins sampled now
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			core_rdata_r <= 8'h00;
		end else if (rd_fire) begin
			unique case (rd_addr_r)
				GPP_OFS_LATCH: core_rdata_r <= latch_q;
				GPP_OFS_DRIVE: core_rdata_r <= drive_q;
				GPP_OFS_PINS:  core_rdata_r <= pin_i;
				default:       core_rdata_r <= GPP_UNMAPPED;
			endcase
		end
	end

	// Completion pulses and busy level
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			core_rd_done_r <= 1'b0;
			core_wr_done_r <= 1'b0;
			core_busy_r    <= 1'b0;
		end else begin
			core_rd_done_r <= rd_fire;
			core_wr_done_r <= wr_fire;
			core_busy_r    <= (rd_pend_r & ~rd_fire) | rd_take | (wr_pend_r & ~wr_fire) | wr_take;
		end
	end

	// Pin levels handed to the shared peripherals
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			periph_in_r <= 8'hFF;
		end else begin
			periph_in_r <= pin_i;
		end
	end

	// One cell per bit
	for (genvar i = 0; i < GPP_WIDTH; i++) begin : g_bit
		gpp_pin_cell u_cell (
			.ref_clk    (ref_clk),
			.rstn       (rstn),
			.wr_latch   (wr_fire && (wr_addr_r == GPP_OFS_LATCH)),
			.wr_drive   (wr_fire && (wr_addr_r == GPP_OFS_DRIVE)),
			.wdata      (wr_data_r[i]),
			.periph_out (periph_out[i]),
			.latch_r    (latch_q[i]),
			.drive_r    (drive_q[i]),
			.pin_o_r    (pin_o[i]),
			.pin_oe_r   (pin_oe[i])
		);
	end

	// Checks
	logic [7:0] lvl;
	assign lvl = (pin_oe & pin_o) | ~pin_oe;

	sequence s_rd_taken;
		rd_take;
	endsequence
	sequence s_rd_back;
		##[1:5] core_rd_done_r;
	endsequence

	property p_reset_vals;
		@(posedge ref_clk) !rstn |=> (latch_q == GPP_LATCH_RST) && (drive_q == GPP_DRIVE_RST);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	property p_rd_first;
		@(posedge ref_clk) disable iff (!rstn)
		core_rd_done_r |-> $past(mstate_r) == GPP_MS_FIRST;
	endproperty
	a_rd_first: assert property (p_rd_first) else $error("read not in first state");

	property p_wr_second;
		@(posedge ref_clk) disable iff (!rstn)
		core_wr_done_r |-> $past(mstate_r) == GPP_MS_SECOND;
	endproperty
	a_wr_second: assert property (p_wr_second) else $error("write not in second state");

	property p_rd_bound;
		@(posedge ref_clk) disable iff (!rstn) s_rd_taken |-> s_rd_back;
	endproperty
	a_rd_bound: assert property (p_rd_bound) else $error("read never completed");

	property p_pins_read;
		@(posedge ref_clk) disable iff (!rstn)
		core_rd_done_r && (rd_addr_r == GPP_OFS_PINS) |-> core_rdata_r == $past(pin_i);
	endproperty
	a_pins_read: assert property (p_pins_read) else $error("pin read wrong");

	property p_latch_read;
		@(posedge ref_clk) disable iff (!rstn)
		core_rd_done_r && (rd_addr_r == GPP_OFS_LATCH) |-> core_rdata_r == $past(latch_q);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

	property p_open_drain;
		@(posedge ref_clk) disable iff (!rstn) (pin_o & ~drive_q) == 8'h00;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

	property p_push_pull;
		@(posedge ref_clk) disable iff (!rstn) (~pin_oe & drive_q) == 8'h00;
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("push-pull released");

	property p_and_drive;
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn) |-> lvl == (latch_q & $past(periph_out));
	endproperty
	a_and_drive: assert property (p_and_drive) else $error("pin level not latch AND peripheral");

	property p_latch_write;
		@(posedge ref_clk) disable iff (!rstn)
		wr_fire && (wr_addr_r == GPP_OFS_LATCH) |=> latch_q == $past(wr_data_r) && core_wr_done_r;
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write lost");
endmodule
`default_nettype wire

//--- gpp_pin_model.sv
// External circuitry on the eight port pins: pull-ups and optional drivers.
// Assumes the bench changes its drive commands just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module gpp_pin_model (
	// Device pad drive
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe,
	// Bench commands
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	// Resolved wire level
	output logic      [7:0] pin_i
);
	// A low on either side wins; a released wire floats up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_i[i] = pin_o[i] & (ext_val[i] | ~ext_en[i]);
			else
				pin_i[i] = ext_en[i] ? ext_val[i] : 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- gpp_port_tb_top.sv
// Self-checking bench for the eight-bit port with an external pin model.
// Assumes the design carries its own assertions; the bench only checks ports.
`timescale 1ns/100ps
`default_nettype none
module gpp_port_tb_top;
	import gpp_pkg::*;
	logic       ref_clk    = 1'b0;
	logic       rstn       = 1'b0;
	logic       core_rd    = 1'b0;
	logic       core_wr    = 1'b0;
	logic [7:0] core_addr  = 8'h00;
	logic [7:0] core_wdata = 8'h00;
	logic [7:0] periph_out = 8'hFF;
	logic [7:0] ext_en     = 8'h00;
	logic [7:0] ext_val    = 8'h00;
	logic [7:0] lat;
	logic [7:0] exp_q[$];
	wire  [7:0] core_rdata_r, periph_in_r, pin_i, pin_o, pin_oe;
	wire        core_rd_done_r, core_wr_done_r, core_busy_r;
	gpp_ms_t    mstate_r;
	int         num_errors = 0;
	int         total_checks = 0;
	int         seed = 92375;

	gpp_port DUT (.ref_clk(ref_clk), .rstn(rstn), .core_addr(core_addr), .core_rd(core_rd),
		.core_wr(core_wr), .core_wdata(core_wdata), .core_rdata_r(core_rdata_r),
		.core_rd_done_r(core_rd_done_r), .core_wr_done_r(core_wr_done_r), .core_busy_r(core_busy_r),
		.periph_out(periph_out), .periph_in_r(periph_in_r), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe(pin_oe), .mstate_r(mstate_r));
	gpp_pin_model PINS (.pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
		.pin_i(pin_i));

	// Clock, 50 ns period
	initial forever #25 ref_clk = ~ref_clk;

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Report and end the run
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Strobe held for the taking edge, then a bounded wait for done
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge ref_clk);
		#1;
		core_addr  = a;
		core_wdata = d;
		core_rd    = ~wr;
		core_wr    = wr;
		@(posedge ref_clk);
		#1;
		core_rd = 1'b0;
		core_wr = 1'b0;
		chk({7'h00, core_busy_r}, 8'h01);
		for (n = 0; n < 8; n++) begin
			if (wr ? core_wr_done_r : core_rd_done_r)
				break;
			@(posedge ref_clk);
			#1;
		end
		if (n == 8)
			chk(8'hEE, 8'h00);
		else
			chk({7'h00, core_busy_r}, 8'h00);
	endtask

	// Read with the expected value noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		access(1'b0, a, 8'h00);
	endtask

	// Takes the oldest note when a read completes; checks done timing
	always @(posedge ref_clk) begin
		if (rstn && core_rd_done_r) begin
			chk(core_rdata_r, exp_q.pop_front());
			chk({6'h00, mstate_r}, {6'h00, GPP_MS_SECOND});
		end
		if (rstn && core_wr_done_r)
			chk({6'h00, mstate_r}, {6'h00, GPP_MS_THIRD});
	end

	// Hang guard
	initial begin
		#(50 * 4000);
		num_errors++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		#1 rstn = 1'b1;
		chk(pin_oe, 8'h00);
		rd(GPP_OFS_LATCH, GPP_LATCH_RST);
		rd(GPP_OFS_DRIVE, GPP_DRIVE_RST);
		rd(GPP_OFS_PINS, 8'hFF);
		rd(8'h20, GPP_UNMAPPED);
		access(1'b1, GPP_OFS_PINS, 8'h12);
		rd(GPP_OFS_LATCH, GPP_LATCH_RST);
		// Open drain: outside drives only the released bits
		for (int k = 0; k < 6; k++) begin
			lat     = 8'($random(seed));
			ext_val = 8'($random(seed));
			ext_en  = lat;
			access(1'b1, GPP_OFS_LATCH, lat);
			chk(pin_oe, ~lat);
			chk(pin_o, 8'h00);
			rd(GPP_OFS_PINS, lat & ext_val);
			rd(GPP_OFS_LATCH, lat);
			chk(periph_in_r, lat & ext_val);
		end
		// Push-pull with the peripheral passed through a high latch
		ext_en = 8'h00;
		access(1'b1, GPP_OFS_LATCH, 8'hFF);
		access(1'b1, GPP_OFS_DRIVE, 8'hFF);
		rd(GPP_OFS_DRIVE, 8'hFF);
		for (int k = 0; k < 4; k++) begin
			periph_out = 8'($random(seed));
			repeat (2) @(posedge ref_clk);
			#1 chk(pin_o, periph_out);
			chk(pin_oe, 8'hFF);
		end
		access(1'b1, GPP_OFS_LATCH, 8'h3C);
		@(posedge ref_clk);
		#1 chk(pin_o, 8'h3C & periph_out);
		rd(GPP_OFS_PINS, 8'h3C & periph_out);
		// Second reset in mid-run, once the last read has been compared
		@(posedge ref_clk);
		#1 rstn = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 chk(pin_oe, 8'h00);
		rstn = 1'b1;
		rd(GPP_OFS_DRIVE, GPP_DRIVE_RST);
		rd(GPP_OFS_LATCH, GPP_LATCH_RST);
		print_verdict();
	end
endmodule
`default_nettype wire
